// File: pvoc_regs.svh
// register offsets, field positions and reset values of the channel control block
// assumes inclusion by the package and by the control module only
`ifndef PVOC_REGS_SVH
`define PVOC_REGS_SVH

`define PVOC_ADDR_COARSE 8'h08
`define PVOC_ADDR_OVR 8'h09
`define PVOC_ADDR_PCLKEN 8'h0D
`define PVOC_ADDR_SDET 8'h14
`define PVOC_ADDR_DIV 8'h18
`define PVOC_ADDR_CPUMP 8'h1B
`define PVOC_ADDR_OUTSEL 8'h1E
`define PVOC_ADDR_CVDAC 8'h1F
`define PVOC_ADDR_PGEN 8'h30

`define PVOC_OVR_DIV 2
`define PVOC_OVR_CP 3
`define PVOC_OVR_QCLK 4
`define PVOC_OVR_MUX 5
`define PVOC_OVR_CVDAC 6
`define PVOC_OVR_COARSE 7
`define PVOC_PCLK_EN_BIT 5
`define PVOC_SDET_FORCE_BIT 7
`define PVOC_SDET_OFF_BIT 6
`define PVOC_PGEN_EN_BIT 4
`define PVOC_PGEN_LOAD_BIT 3
`define PVOC_QCLK_EN_BIT 0

`define PVOC_RST_ZERO 8'h00
`define PVOC_RST_OUTSEL 8'hE0
`define PVOC_RST_CPUMP 8'h03
`define PVOC_RST_COARSE 8'h0C
`define PVOC_RST_CVDAC 8'h12
`define PVOC_SEED9 9'h1FF
`define PVOC_SEED31 31'h7FFFFFFF
`define PVOC_DIV_MAX 3'h4

`define PVOC_DIV_FIELD 6:4
`define PVOC_CPUMP_FIELD 1:0
`define PVOC_CPUMP_STOP 2'h0
`define PVOC_MUX_FIELD 7:5
`define PVOC_PSEL_FIELD 1:0
`define PVOC_TUNE_FIELD 4:0

`endif

// File: pvoc_pkg.sv
// types shared by the channel control block
// assumes pvoc_regs.svh is on the include path
package pvoc_pkg;
    `include "pvoc_regs.svh"

    typedef enum logic [2:0] {
        PVOC_MUX_RAW = 3'h0,
        PVOC_MUX_RETIMED = 3'h1,
        PVOC_MUX_ICLK = 3'h2,
        PVOC_MUX_QCLK = 3'h3,
        PVOC_MUX_PRBS = 3'h4,
        PVOC_MUX_SLOWOSC = 3'h5,
        PVOC_MUX_INVALID = 3'h6,
        PVOC_MUX_MUTE = 3'h7
    } pvoc_mux_e;

    typedef enum logic [1:0] {
        PVOC_PS_PRBS9 = 2'h0,
        PVOC_PS_RSVD1 = 2'h1,
        PVOC_PS_PRBS31 = 2'h2,
        PVOC_PS_RSVD3 = 2'h3
    } pvoc_pattern_e;

    // analog-facing control word of the channel
    typedef struct packed {
        logic [4:0] div_ratio_log2;
        logic channel_enable;
        logic charge_pump_off;
        logic coarse_override;
        logic [4:0] coarse_count;
        logic cv_dac_enable;
        logic [4:0] cv_dac_value;
        logic quad_clk_enable;
    } pvoc_ctrl_s;

    // register write/read port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pvoc_req_s;
endpackage

// File: pvoc_ctrl.sv
// per-channel divider, override and pattern generator control of a serial retimer
// assumes: register port from the channel's serial config slave on clk_i;
// lock, signal-present and auto divider come from the analog CDR on clk_i;
// pattern bits advance once per clk_i edge standing in for the VCO bit clock
`timescale 1ns/100ps
`include "pvoc_regs.svh"

module pvoc_ctrl
    import pvoc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire pvoc_req_s req_i,
    output logic [7:0] rdata_o,
    input wire logic sig_present_i,
    input wire logic cdr_locked_i,
    input wire logic [2:0] auto_div_code_i,
    input wire logic raw_data_i,
    input wire logic retimed_data_i,
    input wire logic iclk_i,
    input wire logic qclk_i,
    input wire logic slow_osc_i,
    output pvoc_ctrl_s ctrl_o,
    output logic loop_locked_mode_o,
    output logic out_data_o,
    output logic out_enable_o
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] coarse_r, coarse_nxt;
    logic [7:0] ovr_r, ovr_nxt;
    logic [7:0] pclk_r, pclk_nxt;
    logic [7:0] sdet_r, sdet_nxt;
    logic [7:0] div_r, div_nxt;
    logic [7:0] cpump_r, cpump_nxt;
    logic [7:0] outsel_r, outsel_nxt;
    logic [7:0] cvdac_r, cvdac_nxt;
    logic [7:0] pgen_r, pgen_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    function automatic logic [7:0] wr_field(input logic [7:0] cur, input logic [7:0] a);
        wr_field = (req_i.wr && req_i.addr == a) ? req_i.wdata : cur;
    endfunction

    always_comb begin
        coarse_nxt = wr_field(coarse_r, `PVOC_ADDR_COARSE);
        ovr_nxt = wr_field(ovr_r, `PVOC_ADDR_OVR);
        pclk_nxt = wr_field(pclk_r, `PVOC_ADDR_PCLKEN);
        sdet_nxt = wr_field(sdet_r, `PVOC_ADDR_SDET);
        div_nxt = wr_field(div_r, `PVOC_ADDR_DIV);
        cpump_nxt = wr_field(cpump_r, `PVOC_ADDR_CPUMP);
        outsel_nxt = wr_field(outsel_r, `PVOC_ADDR_OUTSEL);
        cvdac_nxt = wr_field(cvdac_r, `PVOC_ADDR_CVDAC);
        pgen_nxt = wr_field(pgen_r, `PVOC_ADDR_PGEN);
        rdata_nxt = rdata_r;
        if (req_i.rd) begin
            unique case (req_i.addr)
                `PVOC_ADDR_COARSE: rdata_nxt = coarse_r;
                `PVOC_ADDR_OVR: rdata_nxt = ovr_r;
                `PVOC_ADDR_PCLKEN: rdata_nxt = pclk_r;
                `PVOC_ADDR_SDET: rdata_nxt = sdet_r;
                `PVOC_ADDR_DIV: rdata_nxt = div_r;
                `PVOC_ADDR_CPUMP: rdata_nxt = cpump_r;
                `PVOC_ADDR_OUTSEL: rdata_nxt = outsel_r;
                `PVOC_ADDR_CVDAC: rdata_nxt = cvdac_r;
                `PVOC_ADDR_PGEN: rdata_nxt = pgen_r;
                default: rdata_nxt = `PVOC_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coarse_r <= `PVOC_RST_COARSE;
            ovr_r <= `PVOC_RST_ZERO;
            pclk_r <= `PVOC_RST_ZERO;
            sdet_r <= `PVOC_RST_ZERO;
            div_r <= `PVOC_RST_ZERO;
            cpump_r <= `PVOC_RST_CPUMP;
            outsel_r <= `PVOC_RST_OUTSEL;
            cvdac_r <= `PVOC_RST_CVDAC;
            pgen_r <= `PVOC_RST_ZERO;
            rdata_r <= `PVOC_RST_ZERO;
        end else begin
            coarse_r <= coarse_nxt;
            ovr_r <= ovr_nxt;
            pclk_r <= pclk_nxt;
            sdet_r <= sdet_nxt;
            div_r <= div_nxt;
            cpump_r <= cpump_nxt;
            outsel_r <= outsel_nxt;
            cvdac_r <= cvdac_nxt;
            pgen_r <= pgen_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

    // ----------------------------------------------------------------
    // divider, loop and channel power
    // ----------------------------------------------------------------
    // code n selects ratio 2**n; codes above four clamp to sixteen
    function automatic logic [4:0] div_ratio(input logic [2:0] code);
        logic [2:0] c;
        c = (code > `PVOC_DIV_MAX) ? `PVOC_DIV_MAX : code;
        div_ratio = 5'(5'h01 << c);
    endfunction

    pvoc_ctrl_s ctrl_r, ctrl_nxt;
    logic sd_active;
    logic [2:0] div_code;

    always_comb begin
        // force bit set and power-off bit clear holds the channel up
        sd_active = sig_present_i
            || (sdet_r[`PVOC_SDET_FORCE_BIT] && !sdet_r[`PVOC_SDET_OFF_BIT]);
        div_code = auto_div_code_i;
        if (ovr_r[`PVOC_OVR_DIV]) begin
            div_code = div_r[`PVOC_DIV_FIELD];
        end
        ctrl_nxt.div_ratio_log2 = div_ratio(div_code);
        ctrl_nxt.channel_enable = sd_active;
        ctrl_nxt.charge_pump_off = ovr_r[`PVOC_OVR_CP]
            && (cpump_r[`PVOC_CPUMP_FIELD] == `PVOC_CPUMP_STOP);
        ctrl_nxt.coarse_override = ovr_r[`PVOC_OVR_COARSE];
        ctrl_nxt.coarse_count = coarse_r[`PVOC_TUNE_FIELD];
        ctrl_nxt.cv_dac_enable = ovr_r[`PVOC_OVR_CVDAC];
        ctrl_nxt.cv_dac_value = cvdac_r[`PVOC_TUNE_FIELD];
        ctrl_nxt.quad_clk_enable = ovr_r[`PVOC_OVR_QCLK] && outsel_r[`PVOC_QCLK_EN_BIT];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign ctrl_o = ctrl_r;
    // loop tracks input independent of mux; lock loss or pump-off releases it
    assign loop_locked_mode_o = cdr_locked_i && !ctrl_r.charge_pump_off;

    // ----------------------------------------------------------------
    // pattern generator
    // ----------------------------------------------------------------
    // only code two runs the long sequence; reserved codes run the short one
    function automatic logic long_pattern(input pvoc_pattern_e sel);
        long_pattern = (sel == PVOC_PS_PRBS31);
    endfunction

    logic [30:0] lfsr_r, lfsr_nxt;
    logic gen_en, gen_run;
    pvoc_pattern_e pat_sel;

    always_comb begin
        gen_en = outsel_r[`PVOC_PGEN_EN_BIT];
        pat_sel = pvoc_pattern_e'(pgen_r[`PVOC_PSEL_FIELD]);
        gen_run = gen_en && pgen_r[`PVOC_PGEN_LOAD_BIT] && pclk_r[`PVOC_PCLK_EN_BIT];
        lfsr_nxt = lfsr_r;
        if (!gen_en || !pgen_r[`PVOC_PGEN_LOAD_BIT]) begin
            // clock held in reset: preload seed for the chosen length
            lfsr_nxt = long_pattern(pat_sel) ? `PVOC_SEED31
                : {22'h0, `PVOC_SEED9};
        end else if (gen_run) begin
            unique case (pat_sel)
                PVOC_PS_PRBS31:
                    lfsr_nxt = {lfsr_r[29:0], lfsr_r[30] ^ lfsr_r[27]};
                default:
                    lfsr_nxt = {22'h0, lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lfsr_r <= '0;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    logic pat_bit;
    assign pat_bit = gen_en && (long_pattern(pat_sel) ? lfsr_r[30] : lfsr_r[8]);

    // ----------------------------------------------------------------
    // output multiplexer
    // ----------------------------------------------------------------
    function automatic pvoc_mux_e mux_code(input logic [7:0] ctl);
        mux_code = pvoc_mux_e'(ctl[`PVOC_MUX_FIELD]);
    endfunction

    logic out_r, out_nxt, oen_r, oen_nxt;
    pvoc_mux_e mux_sel;

    always_comb begin
        if (ovr_r[`PVOC_OVR_MUX]) begin
            mux_sel = mux_code(outsel_r);
        end else if (cdr_locked_i) begin
            mux_sel = PVOC_MUX_RETIMED;
        end else begin
            mux_sel = mux_code(outsel_r);
        end
        out_nxt = 1'b0;
        oen_nxt = sd_active;
        unique case (mux_sel)
            PVOC_MUX_RAW: out_nxt = raw_data_i;
            PVOC_MUX_RETIMED: out_nxt = retimed_data_i;
            PVOC_MUX_ICLK: out_nxt = iclk_i;
            PVOC_MUX_QCLK: out_nxt = qclk_i && ctrl_r.quad_clk_enable;
            PVOC_MUX_PRBS: out_nxt = pat_bit;
            PVOC_MUX_SLOWOSC: out_nxt = slow_osc_i;
            PVOC_MUX_INVALID: oen_nxt = 1'b0;
            PVOC_MUX_MUTE: oen_nxt = 1'b0;
        endcase
        if (!sd_active) begin
            out_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_r <= 1'b0;
            oen_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            oen_r <= oen_nxt;
        end
    end

    assign out_data_o = out_r;
    assign out_enable_o = oen_r;
endmodule

// File: pvoc_ctrl_asserts.sv
// port checks of the channel control block
// assumes bind onto pvoc_ctrl, one clock, async low reset
`timescale 1ns/100ps
module pvoc_ctrl_asserts
    import pvoc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire pvoc_req_s req_i,
    input wire logic sig_present_i,
    input wire logic cdr_locked_i,
    input wire logic [2:0] auto_div_code_i,
    input wire logic retimed_data_i,
    input wire pvoc_ctrl_s ctrl_o,
    input wire logic out_data_o,
    input wire logic out_enable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // shadow registers
    // ----
    logic [7:0] ov_r, dv_r, os_r, sd_r, cp_r;
    logic [4:0] dexp, aexp;
    assign dexp = (dv_r[6:4] > 3'h4) ? 5'h10 : 5'h01 << dv_r[6:4];
    assign aexp = (auto_div_code_i > 3'h4) ? 5'h10 : 5'h01 << auto_div_code_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {ov_r, dv_r, os_r, sd_r, cp_r} <= 40'h0000E00003;
        end else if (req_i.wr) begin
            case (req_i.addr)
                8'h09: ov_r <= req_i.wdata;
                8'h18: dv_r <= req_i.wdata;
                8'h1E: os_r <= req_i.wdata;
                8'h14: sd_r <= req_i.wdata;
                8'h1B: cp_r <= req_i.wdata;
                default: ;
            endcase
        end
    end
    // registers and inputs quiet long enough for outputs to follow
    sequence calm;
        (!req_i.wr && $stable({sig_present_i, cdr_locked_i, auto_div_code_i})) [*3];
    endsequence
    // every override cleared in one write, then two quiet cycles
    sequence ovr_zeroed;
        (req_i.wr && req_i.addr == 8'h09 && req_i.wdata == 8'h00) ##1 !req_i.wr [*2];
    endsequence
    chk_div_manual: assert property (
        calm |-> !ov_r[2] || ctrl_o.div_ratio_log2 == dexp)
        else $error("manual ratio wrong");
    chk_div_auto: assert property (
        calm |-> ov_r[2] || ctrl_o.div_ratio_log2 == aexp)
        else $error("auto ratio wrong");
    chk_pump_off: assert property (
        calm |-> ctrl_o.charge_pump_off == (ov_r[3] && cp_r[1:0] == 2'h0))
        else $error("pump state wrong");
    chk_vco_ovr: assert property (
        calm |-> {ctrl_o.coarse_override, ctrl_o.cv_dac_enable} == ov_r[7:6])
        else $error("vco override wrong");
    chk_no_input: assert property (
        calm ##0 (!sig_present_i && sd_r[7:6] != 2'h2)
        |-> !ctrl_o.channel_enable && !out_enable_o)
        else $error("channel not off");
    chk_force_on: assert property (
        calm ##0 (sd_r[7:6] == 2'h2) |-> ctrl_o.channel_enable)
        else $error("force ignored");
    chk_mute_code: assert property (
        calm ##0 (os_r[7:6] == 2'h3 && (ov_r[5] || !cdr_locked_i)) |-> !out_enable_o)
        else $error("not muted");
    chk_retimed_data: assert property (
        calm ##0 (sig_present_i && cdr_locked_i && !ov_r[5])
        |-> out_enable_o && out_data_o == $past(retimed_data_i))
        else $error("retimed not out");
    chk_ovr_clear: assert property (
        ovr_zeroed
        |-> !ctrl_o.coarse_override && !ctrl_o.cv_dac_enable && !ctrl_o.charge_pump_off)
        else $error("overrides kept");
endmodule
bind pvoc_ctrl pvoc_ctrl_asserts pvoc_ctrl_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .sig_present_i(sig_present_i), .cdr_locked_i(cdr_locked_i),
    .auto_div_code_i(auto_div_code_i), .retimed_data_i(retimed_data_i), .ctrl_o(ctrl_o),
    .out_data_o(out_data_o), .out_enable_o(out_enable_o));

// File: pvoc_rx_model.sv
// downstream receiver keeping the last 64 bits of the channel output
// assumes one bit per clk_i edge; bits taken only while the driver is on
`timescale 1ns/100ps
module pvoc_rx_model (
    input wire logic clk_i,
    input wire logic data_i,
    input wire logic enable_i,
    output logic [63:0] hist_o
);
    always_ff @(posedge clk_i) begin
        if (enable_i) begin
            hist_o <= {hist_o[62:0], data_i};
        end
    end
endmodule

// File: pvoc_ctrl_tb_top.sv
// testbench of the channel control block with a downstream receiver
// assumes pvoc_pkg, pvoc_ctrl, the checker and the receiver model compiled first
`timescale 1ns/100ps
module pvoc_ctrl_tb_top;
    import pvoc_pkg::*;
    localparam logic [7:0] ADR [10] = '{8'h08, 8'h09, 8'h0D, 8'h14, 8'h18,
        8'h1B, 8'h1E, 8'h1F, 8'h30, 8'h55};
    localparam logic [7:0] RST [10] = '{8'h0C, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h03, 8'hE0, 8'h12, 8'h00, 8'h00};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    pvoc_req_s req_i = '0;
    logic sig_i = 1'b0;
    logic lock_i = 1'b0;
    logic [2:0] adiv_i = 3'h0;
    logic [4:0] src = 5'h00;
    logic [7:0] rdata_o;
    pvoc_ctrl_s ctrl_o;
    logic llm_o, dat_o, en_o;
    logic [63:0] hist;
    int fail_count = 0;
    int comparisons = 0;
    always #50 clk_i = ~clk_i;
    pvoc_ctrl pvoc_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o),
        .sig_present_i(sig_i), .cdr_locked_i(lock_i), .auto_div_code_i(adiv_i),
        .raw_data_i(src[0]), .retimed_data_i(src[1]), .iclk_i(src[2]), .qclk_i(src[3]),
        .slow_osc_i(src[4]), .ctrl_o(ctrl_o), .loop_locked_mode_o(llm_o), .out_data_o(dat_o),
        .out_enable_o(en_o));
    pvoc_rx_model pvoc_rx_model_inst (.clk_i(clk_i), .data_i(dat_o), .enable_i(en_o),
        .hist_o(hist));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i);
        req_i <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic t_regs;
        logic [7:0] v;
        for (int i = 0; i < 10; i++) begin
            rd(ADR[i], v);
            chk("reset", RST[i], v);
            wr(ADR[i], 8'hA5);
            rd(ADR[i], v);
            chk("readback", (i < 9) ? 8'hA5 : 8'h00, v);
            wr(ADR[i], RST[i]);
        end
    endtask
    task automatic t_div;
        for (int c = 0; c < 5; c++) begin
            adiv_i <= c[2:0];
            wr(8'h18, {1'b0, 3'h4 - c[2:0], 4'h0});
            settle;
            chk("auto ratio", 8'h01 << c, {3'h0, ctrl_o.div_ratio_log2});
            wr(8'h09, 8'h04);
            settle;
            chk("manual ratio", 8'h10 >> c, {3'h0, ctrl_o.div_ratio_log2});
            wr(8'h09, 8'h00);
        end
    endtask
    task automatic t_free;
        lock_i <= 1'b1;
        wr(8'h14, 8'h80);
        wr(8'h09, 8'h08);
        wr(8'h1B, 8'h00);
        wr(8'h09, 8'h0C);
        wr(8'h18, 8'h00);
        wr(8'h09, 8'h8C);
        wr(8'h08, 8'h0C);
        wr(8'h09, 8'hCC);
        wr(8'h1F, 8'h12);
        settle;
        chk("chan pump loop", 8'h06,
            {ctrl_o.channel_enable, ctrl_o.charge_pump_off, llm_o});
        chk("coarse", 8'h2C, {2'h0, ctrl_o.coarse_override, ctrl_o.coarse_count});
        chk("cv dac", 8'h32, {2'h0, ctrl_o.cv_dac_enable, ctrl_o.cv_dac_value});
        wr(8'h09, 8'h00);
        wr(8'h14, 8'h00);
        settle;
        chk("cleared", 8'h00, {ctrl_o.channel_enable, ctrl_o.charge_pump_off});
    endtask
    task automatic t_prbs(input logic [1:0] sel, input int t1, input int t2);
        int bad;
        bad = 0;
        sig_i <= 1'b1;
        wr(8'h1E, 8'hF0);
        wr(8'h30, 8'h00);
        wr(8'h30, {6'h00, sel});
        wr(8'h30, {6'h02, sel});
        wr(8'h0D, 8'h20);
        wr(8'h09, 8'h20);
        wr(8'h1E, 8'h90);
        repeat (80) @(posedge clk_i);
        for (int a = 0; a < 33; a++) begin
            bad += int'(hist[a] !== (hist[a + t1] ^ hist[a + t2]));
        end
        chk("prbs taps", 8'h00, bad[7:0]);
        chk("prbs live", 8'h03, {6'h0, en_o, |hist});
        wr(8'h1E, 8'h80);
        repeat (12) @(posedge clk_i);
        chk("gen off quiet", 8'h00, hist[7:0]);
        wr(8'h09, 8'h00);
    endtask
    task automatic t_mux;
        logic [2:0] c;
        wr(8'h09, 8'h30);
        for (int k = 0; k < 8; k++) begin
            c = k[2:0];
            if (c != 3'h4) begin
                wr(8'h1E, {c, 5'h01});
                src <= (c == 3'h5) ? 5'h10 : 5'h01 << c;
                settle;
                chk("mux on", {6'h0, c < 3'h6, c < 3'h6}, {6'h0, en_o, dat_o & en_o});
                chk("loop locked", 8'h01, {7'h00, llm_o});
            end
        end
        wr(8'h09, 8'h00);
        lock_i <= 1'b0;
        wr(8'h1E, 8'h00);
        src <= 5'h01;
        settle;
        chk("unlocked raw", 8'h03, {6'h0, en_o, dat_o});
        lock_i <= 1'b1;
        src <= 5'h02;
        settle;
        chk("locked retimed", 8'h03, {6'h0, en_o, dat_o});
    endtask
    task automatic final_report;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_div;
        t_free;
        t_prbs(2'h0, 5, 9);
        t_prbs(2'h2, 28, 31);
        t_mux;
        final_report;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        final_report;
    end
endmodule
